// ==== inc/fcm_defines.svh ====
`ifndef FCM_DEFINES_SVH
`define FCM_DEFINES_SVH

// Register byte offsets
`define FCM_PADDR_W        12
`define FCM_OFF_CTRL       12'h000
`define FCM_OFF_STATUS     12'h004
`define FCM_OFF_IRQ_MASK   12'h008

// Control fields
`define FCM_CTRL_INV_EN    0
`define FCM_CTRL_COP_EN    1
`define FCM_CTRL_W         2
`define FCM_CTRL_RESET     2'h2

// Status and mask fields
`define FCM_ST_INVALID     0
`define FCM_ST_RESERVED    1
`define FCM_ST_UNIMPL      2
`define FCM_ST_UNUSABLE    3
`define FCM_ST_W           4
`define FCM_STATUS_RESET   4'h0
`define FCM_MASK_RESET     4'h0

// Condition field bits
`define FCM_CB_NEG         4
`define FCM_CB_SIG         3
`define FCM_CB_LT          2
`define FCM_CB_EQ          1
`define FCM_CB_UN          0

// One bit per condition code, set where the code is reserved
`define FCM_CONDN_RESERVED 32'hF1F1_0000

// Operand formats
`define FCM_FMT_S          2'h0
`define FCM_FMT_D          2'h1
`define FCM_FMT_W          2'h2
`define FCM_FMT_L          2'h3
`define FCM_SGL_W          32
`define FCM_DBL_W          64

`endif

// ==== inc/fcm_pkg.sv ====
`include "fcm_defines.svh"

package fcm_pkg;

    typedef enum logic [1:0] {
        FCM_FMT_SINGLE = `FCM_FMT_S,
        FCM_FMT_DOUBLE = `FCM_FMT_D,
        FCM_FMT_WORD   = `FCM_FMT_W,
        FCM_FMT_LONG   = `FCM_FMT_L
    } fcm_fmt_t;

    typedef struct packed {
        logic        valid;
        fcm_fmt_t    fmt;
        logic [4:0]  condn;
        logic [4:0]  dest;
        logic [63:0] first_src;
        logic [63:0] second_src;
    } fcm_req_t;

    typedef struct packed {
        logic        valid;
        logic        wr_en;
        logic [4:0]  dest;
        logic [63:0] mask;
        logic        inv_flag;
        logic        exc_invalid;
        logic        exc_reserved;
        logic        exc_unimpl;
        logic        exc_unusable;
    } fcm_res_t;

    typedef struct packed {
        logic        signalling_not_a_number;
        logic        quiet_not_a_number;
        logic        zero;
        logic        sign;
        logic [62:0] mag;
    } fcm_cls_t;

    typedef struct packed {
        fcm_res_t    res;
        logic [1:0]  ctrl;
        logic [3:0]  status;
        logic [3:0]  irq_mask;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } fcm_state_t;

endpackage

// ==== verilog/fcm_operand_classify.sv ====
module fcm_operand_classify (
    input  wire logic             i_dbl,
    input  wire logic [63:0]      i_val,
    output fcm_pkg::fcm_cls_t     o_cls
);
    import fcm_pkg::*;

    logic        exp_ones;
    logic        frac_nz;
    logic        quiet_bit;
    logic [62:0] mag;

    always_comb
    begin
        if (i_dbl)
        begin
            exp_ones   = &i_val[62:52];
            frac_nz    = |i_val[51:0];
            quiet_bit  = i_val[51];
            mag        = i_val[62:0];
            o_cls.sign = i_val[63];
        end
        else
        begin
            // Upper half ignored for single operands
            exp_ones   = &i_val[30:23];
            frac_nz    = |i_val[22:0];
            quiet_bit  = i_val[22];
            mag        = {32'h0, i_val[30:0]};
            o_cls.sign = i_val[31];
        end
        o_cls.mag  = mag;
        o_cls.zero = (mag == 63'h0);
        o_cls.quiet_not_a_number = exp_ones & frac_nz & quiet_bit;
        o_cls.signalling_not_a_number = exp_ones & frac_nz & ~quiet_bit;
    end

endmodule

// ==== verilog/fcm_magnitude_compare.sv ====
module fcm_magnitude_compare (
    input  fcm_pkg::fcm_cls_t i_a,
    input  fcm_pkg::fcm_cls_t i_b,
    output logic              o_less,
    output logic              o_equal
);
    import fcm_pkg::*;

    logic both_zero;

    always_comb
    begin
        // Sign of zero never matters
        both_zero = i_a.zero & i_b.zero;
        o_equal   = both_zero | ((i_a.sign == i_b.sign) && (i_a.mag == i_b.mag));
        if (both_zero)
            o_less = 1'b0;
        else if (i_a.sign != i_b.sign)
            o_less = i_a.sign;
        else if (!i_a.sign)
            o_less = (i_a.mag < i_b.mag);
        else
            o_less = (i_a.mag > i_b.mag);
    end

endmodule

// ==== verilog/fcm_compare_unit.sv ====
// Function
// - Exactly one ordering relation holds per pair
// - Any NaN operand makes relation unordered
// - Positive and negative zero compare equal
// - Condition field selects among sixteen predicates
// - Result is bit4 xor masked relation terms
// - NaN forces unordered, else numeric less/equal
// - Signalling NaN raises invalid operation on every unblocked request
// - Signalling codes also trap on quiet NaN
// - Low codes pick the quiet positive predicates
// - Bit4 complements predicate in one operation
// - Replicate condition bit across format width
// - Unimplemented condition codes are reserved
// - Report unusable, reserved, unimplemented, invalid
// - Mask all ones or zeros, width-limited
// - Invalid sets flag; enabled trap suppresses write
// - Reserved code raises exception, no mask
`include "fcm_defines.svh"

module fcm_compare_unit (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  fcm_pkg::fcm_req_t              i_req,
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [`FCM_PADDR_W-1:0]   i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic [31:0]                    o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    output logic                           o_irq,
    output fcm_pkg::fcm_res_t              o_res
);
    import fcm_pkg::*;

    fcm_state_t q;
    fcm_state_t d;

    fcm_cls_t   cls_a;
    fcm_cls_t   cls_b;
    logic       num_less;
    logic       num_equal;
    logic       is_dbl;
    logic       any_signalling_not_a_number;
    logic       any_quiet_not_a_number;
    logic       rel_less;
    logic       rel_equal;
    logic       rel_unord;
    logic       cond_bit;
    logic       invalid_cond;
    logic       reserved_code;
    logic       unimpl_fmt;
    logic       unusable;
    logic       blocked;
    logic       inv_raise;
    logic       inv_trap;
    logic [63:0] mask;
    logic [3:0] events;
    logic       access;
    logic       done;
    logic       hit;
    logic [31:0] rdata;
    logic [3:0] rd_clear;

    // Magnitude format follows the request
    assign is_dbl = (i_req.fmt == FCM_FMT_DOUBLE);

    fcm_operand_classify u_cls_a (
        .i_dbl (is_dbl),
        .i_val (i_req.first_src),
        .o_cls (cls_a)
    );

    fcm_operand_classify u_cls_b (
        .i_dbl (is_dbl),
        .i_val (i_req.second_src),
        .o_cls (cls_b)
    );

    fcm_magnitude_compare u_cmp (
        .i_a     (cls_a),
        .i_b     (cls_b),
        .o_less  (num_less),
        .o_equal (num_equal)
    );

    always_comb
    begin
        any_signalling_not_a_number = cls_a.signalling_not_a_number | cls_b.signalling_not_a_number;
        any_quiet_not_a_number = cls_a.quiet_not_a_number | cls_b.quiet_not_a_number;
        // NaN, even against itself, is unordered
        if (any_signalling_not_a_number | any_quiet_not_a_number)
        begin
            rel_less  = 1'b0;
            rel_equal = 1'b0;
            rel_unord = 1'b1;
        end
        else
        begin
            rel_less  = num_less;
            rel_equal = num_equal;
            rel_unord = 1'b0;
        end
        // Bits 2..0 pick the predicate, bit 4 negates it
        cond_bit = i_req.condn[`FCM_CB_NEG] ^
                   ((i_req.condn[`FCM_CB_LT] & rel_less) |
                    (i_req.condn[`FCM_CB_EQ] & rel_equal) |
                    (i_req.condn[`FCM_CB_UN] & rel_unord));
        invalid_cond = any_signalling_not_a_number |
                       (i_req.condn[`FCM_CB_SIG] & any_quiet_not_a_number);
        reserved_code = |(`FCM_CONDN_RESERVED & (32'h1 << i_req.condn));
        unimpl_fmt = (i_req.fmt != FCM_FMT_SINGLE) && !is_dbl;
        unusable   = !q.ctrl[`FCM_CTRL_COP_EN];
    end

    always_comb
    begin
        // Upper half zero for single; callers must not rely on it
        if (is_dbl)
            mask = {64{cond_bit}};
        else
            mask = {32'h0, {32{cond_bit}}};
        // Unusable beats reserved beats unimplemented beats invalid
        blocked   = unusable | reserved_code | unimpl_fmt;
        inv_raise = i_req.valid & !blocked & invalid_cond;
        inv_trap  = inv_raise & q.ctrl[`FCM_CTRL_INV_EN];
        events = '0;
        events[`FCM_ST_INVALID]  = inv_raise;
        events[`FCM_ST_RESERVED] = i_req.valid & !unusable & reserved_code;
        events[`FCM_ST_UNIMPL]   = i_req.valid & !unusable & !reserved_code & unimpl_fmt;
        events[`FCM_ST_UNUSABLE] = i_req.valid & unusable;
    end

    always_comb
    begin
        access   = i_psel & i_penable;
        done     = access & q.pready;
        hit      = 1'b1;
        rdata    = 32'h0;
        rd_clear = '0;
        case (i_paddr)
            `FCM_OFF_CTRL:
            begin
                rdata[`FCM_CTRL_W-1:0] = q.ctrl;
            end
            `FCM_OFF_STATUS:
            begin
                rdata[`FCM_ST_W-1:0] = q.status;
                // Clear only what the read returned; later events survive
                rd_clear = {`FCM_ST_W{done & !i_pwrite}} & q.prdata[`FCM_ST_W-1:0];
            end
            `FCM_OFF_IRQ_MASK:
            begin
                rdata[`FCM_ST_W-1:0] = q.irq_mask;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        d = q;

        // Result stage
        d.res              = '0;
        d.res.valid        = i_req.valid;
        d.res.dest         = i_req.dest;
        d.res.inv_flag     = inv_raise;
        d.res.exc_invalid  = inv_trap;
        d.res.exc_reserved = events[`FCM_ST_RESERVED];
        d.res.exc_unimpl   = events[`FCM_ST_UNIMPL];
        d.res.exc_unusable = events[`FCM_ST_UNUSABLE];
        d.res.wr_en        = i_req.valid & !blocked & !inv_trap;
        if (i_req.valid & !blocked)
            d.res.mask = mask;

        // One wait state: pready rises in the second access cycle
        d.pready  = access & ~q.pready;
        d.pslverr = access & ~q.pready & ~hit;
        if (access & ~q.pready)
            d.prdata = i_pwrite ? 32'h0 : rdata;
        else
            d.prdata = 32'h0;

        // Writes land only on the completing edge
        if (done & i_pwrite & hit)
        begin
            if (i_paddr == `FCM_OFF_CTRL)
                d.ctrl = i_pwdata[`FCM_CTRL_W-1:0];
            if (i_paddr == `FCM_OFF_IRQ_MASK)
                d.irq_mask = i_pwdata[`FCM_ST_W-1:0];
        end

        // New events win over a read-clear in the same cycle
        d.status = (q.status & ~rd_clear) | events;
        d.irq    = |(d.status & d.irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q          <= '0;
            q.ctrl     <= `FCM_CTRL_RESET;
            q.status   <= `FCM_STATUS_RESET;
            q.irq_mask <= `FCM_MASK_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_res     = q.res;
    assign o_prdata  = q.prdata;
    assign o_pready  = q.pready;
    assign o_pslverr = q.pslverr;
    assign o_irq     = q.irq;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic ok_req;
    assign ok_req = i_req.valid & !blocked;

    property p_one_relation;
        i_req.valid |-> !(rel_less && rel_equal) && !(rel_unord && (rel_less || rel_equal));
    endproperty
    a_one_relation: assert property (p_one_relation)
        else $error("more than one ordering relation true");

    property p_nan_unordered;
        i_req.valid && (cls_a.quiet_not_a_number || cls_a.signalling_not_a_number) |-> rel_unord && !rel_equal;
    endproperty
    a_nan_unordered: assert property (p_nan_unordered)
        else $error("NaN operand not unordered");

    property p_zero_equal;
        ok_req && cls_a.zero && cls_b.zero && i_req.condn == 5'h02 |=> o_res.mask[0];
    endproperty
    a_zero_equal: assert property (p_zero_equal)
        else $error("signed zeros not equal");

    property p_always_false;
        ok_req && i_req.condn[3:0] == 4'h0 |=> o_res.mask[0] == $past(i_req.condn[4]);
    endproperty
    a_always_false: assert property (p_always_false)
        else $error("always-false code gave wrong result");

    property p_ordered_code;
        ok_req && i_req.condn == 5'h11 |=> o_res.mask[0] == !$past(rel_unord);
    endproperty
    a_ordered_code: assert property (p_ordered_code)
        else $error("ordered predicate wrong");

    property p_less_code;
        ok_req && i_req.condn == 5'h04 |=> o_res.mask[0] == $past(rel_less);
    endproperty
    a_less_code: assert property (p_less_code)
        else $error("less predicate wrong");

    property p_signalling_not_a_number_invalid;
        ok_req && any_signalling_not_a_number |=> o_res.inv_flag;
    endproperty
    a_signalling_not_a_number_invalid: assert property (p_signalling_not_a_number_invalid)
        else $error("signalling NaN did not raise invalid");

    property p_quiet_codes;
        ok_req && !i_req.condn[3] && !any_signalling_not_a_number |=> !o_res.inv_flag;
    endproperty
    a_quiet_codes: assert property (p_quiet_codes)
        else $error("quiet code raised invalid without signalling NaN");

    property p_mask_shape;
        o_res.wr_en |-> (o_res.mask[31:0] == 32'h0 || o_res.mask[31:0] == 32'hFFFF_FFFF)
            && (o_res.mask[63:32] == ($past(is_dbl) ? o_res.mask[31:0] : 32'h0));
    endproperty
    a_mask_shape: assert property (p_mask_shape)
        else $error("mask not replicated over format width");

    property p_trap_suppress;
        inv_raise && q.ctrl[`FCM_CTRL_INV_EN] |=> o_res.exc_invalid && !o_res.wr_en;
    endproperty
    a_trap_suppress: assert property (p_trap_suppress)
        else $error("enabled invalid trap did not suppress write");

    property p_reserved;
        i_req.valid && !unusable && reserved_code
            |=> o_res.exc_reserved && !o_res.wr_en && !o_res.inv_flag;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code not trapped");

    property p_unimpl;
        i_req.valid && !unusable && !reserved_code && unimpl_fmt |=> o_res.exc_unimpl;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented format not reported");

    property p_latency;
        i_req.valid |=> o_res.valid && o_res.dest == $past(i_req.dest);
    endproperty
    a_latency: assert property (p_latency)
        else $error("result valid not one cycle after request");

    property p_idle_quiet;
        !i_req.valid |=> !o_res.valid && !o_res.wr_en && o_res.mask == 64'h0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("result shown without a request");

    property p_unusable;
        i_req.valid && unusable
            |=> o_res.exc_unusable && !o_res.wr_en && !o_res.exc_reserved && !o_res.inv_flag;
    endproperty
    a_unusable: assert property (p_unusable)
        else $error("disabled unit did not report unusable");

    property p_quiet_not_a_number_signal;
        ok_req && i_req.condn[`FCM_CB_SIG] && any_quiet_not_a_number |=> o_res.inv_flag;
    endproperty
    a_quiet_not_a_number_signal: assert property (p_quiet_not_a_number_signal)
        else $error("signalling code ignored quiet NaN");

    property p_trap_off;
        inv_raise && !q.ctrl[`FCM_CTRL_INV_EN] |=> o_res.wr_en && !o_res.exc_invalid;
    endproperty
    a_trap_off: assert property (p_trap_off)
        else $error("disabled invalid trap blocked the write");

    property p_not_equal;
        ok_req && i_req.condn == 5'h12 |=> o_res.mask[0] == !$past(rel_equal);
    endproperty
    a_not_equal: assert property (p_not_equal)
        else $error("not-equal predicate wrong");

    property p_status_sticky;
        (|events) |=> (q.status & $past(events)) == $past(events);
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("exception event lost from status");

endmodule

// ==== dv/fcm_issue_model.sv ====
module fcm_issue_model (
    input  wire logic         i_swap,
    input  fcm_pkg::fcm_req_t i_cmd,
    output fcm_pkg::fcm_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcm_pkg::*;

    always_comb
    begin
        o_req = i_cmd;
        if (i_swap)
        begin
            o_req.first_src  = i_cmd.second_src;
            o_req.second_src = i_cmd.first_src;
        end
        if (!i_cmd.valid)
        begin
            // Idle operands inverted so stale values never look live
            o_req.first_src  = ~i_cmd.first_src;
            o_req.second_src = ~i_cmd.second_src;
        end
    end
endmodule

// ==== dv/fcm_compare_unit_tb.sv ====
`include "fcm_defines.svh"

module fcm_compare_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcm_pkg::*;

    // Flags: dbl swap lt eq un sn qn
    typedef struct packed {
        logic [63:0] a;
        logic [63:0] b;
        logic        dbl;
        logic        swap;
        logic        lt;
        logic        eq;
        logic        un;
        logic        sn;
        logic        qn;
    } fcm_row_t;

    localparam logic [31:0] RSV_CODES = 32'hF1F1_0000;

    fcm_row_t    rows [11] = '{
        {64'h3F80_0000, 64'h4000_0000, 7'h10},
        {64'h4000_0000, 64'h3F80_0000, 7'h00},
        {64'h0000_0000, 64'h8000_0000, 7'h08},
        {64'h7FC0_0000, 64'h3F80_0000, 7'h05},
        {64'h7F80_0001, 64'h7F80_0001, 7'h06},
        {64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 7'h50},
        {64'h7FF8_0000_0000_0000, 64'h7FF8_0000_0000_0000, 7'h45},
        {64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 7'h60},
        {64'h7FF8_0000_3F80_0000, 64'h3F80_0000, 7'h08},
        {64'hBF80_0000, 64'h3F80_0000, 7'h10},
        {64'h7FF0_0000_0000_0001, 64'h3FF0_0000_0000_0000, 7'h46}
    };
    logic        i_clk;
    logic        i_rst_n;
    fcm_req_t    cmd;
    fcm_req_t    req;
    logic        swap;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    fcm_res_t    res;
    fcm_res_t    pexp;
    logic        pend;
    int          miscompares;
    int          cmp_count;

    fcm_issue_model u_fcm_issue_model (.i_swap(swap), .i_cmd(cmd), .o_req(req));

    fcm_compare_unit u_fcm_compare_unit (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_res(res)
    );

    initial
    begin
        i_clk = 1'h0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_res(input fcm_res_t e);
        cmp_count++;
        if (res !== e)
        begin
            miscompares++;
            $display("MISMATCH o_res expected %h seen %h", e, res);
        end
    endtask

    // Results checked one edge later, so steps must run on consecutive edges
    task automatic step(input fcm_req_t r, input logic s, input fcm_res_t e);
        @(posedge i_clk);
        cmd  <= r;
        swap <= s;
        #1;
        if (pend)
            chk_res(pexp);
        pexp = e;
        pend = r.valid;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic ee);
        int n;
        n = 0;
        @(posedge i_clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'h1;
        @(posedge i_clk);
        while (pready !== 1'h1 && n < 20)
        begin
            n++;
            @(posedge i_clk);
        end
        chk_val("pready", 64'h1, {63'h0, pready});
        if (!w)
            chk_val("prdata", {32'h0, e}, {32'h0, prdata});
        chk_val("pslverr", {63'h0, ee}, {63'h0, pslverr});
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic fcm_res_t mk(input fcm_row_t w, input logic [4:0] c);
        fcm_res_t e;
        logic     t;
        e = '0;
        e.valid = 1'h1;
        e.dest = c;
        if (RSV_CODES[c])
        begin
            e.exc_reserved = 1'h1;
            return e;
        end
        t = c[4] ^ ((c[2] & w.lt) | (c[1] & w.eq) | (c[0] & w.un));
        e.wr_en = 1'h1;
        e.inv_flag = w.sn | (c[3] & w.qn);
        e.mask = w.dbl ? {64{t}} : {32'h0, {32{t}}};
        return e;
    endfunction

    initial
    begin
        fcm_req_t r;
        fcm_res_t e;
        i_rst_n = 1'h0;
        cmd = '0;
        swap = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pend = 1'h0;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'h1;
        foreach (rows[i])
            for (int c = 0; c < 32; c++)
            begin
                r = '0;
                r.valid = 1'h1;
                r.fmt = rows[i].dbl ? FCM_FMT_DOUBLE : FCM_FMT_SINGLE;
                r.condn = c[4:0];
                r.dest = c[4:0];
                r.first_src = rows[i].a;
                r.second_src = rows[i].b;
                e = mk(rows[i], c[4:0]);
                step(r, rows[i].swap, e);
            end
        step('0, 1'h0, '0);
        chk_val("irq", 64'h0, {63'h0, irq});
        apb(1'h0, `FCM_OFF_STATUS, 32'h0, 32'h3, 1'h0);
        apb(1'h0, `FCM_OFF_STATUS, 32'h0, 32'h0, 1'h0);
        apb(1'h0, 12'h00C, 32'h0, 32'h0, 1'h1);
        apb(1'h1, `FCM_OFF_IRQ_MASK, 32'hF, 32'h0, 1'h0);
        apb(1'h1, `FCM_OFF_CTRL, 32'h3, 32'h0, 1'h0);
        r = '0;
        r.valid = 1'h1;
        r.first_src = 64'h7F80_0001;
        r.second_src = 64'h3F80_0000;
        e = '0;
        e.valid = 1'h1;
        e.inv_flag = 1'h1;
        e.exc_invalid = 1'h1;
        step(r, 1'h0, e);
        step('0, 1'h0, '0);
        repeat (2) @(posedge i_clk);
        #1;
        chk_val("irq", 64'h1, {63'h0, irq});
        apb(1'h0, `FCM_OFF_STATUS, 32'h0, 32'h1, 1'h0);
        repeat (2) @(posedge i_clk);
        #1;
        chk_val("irq", 64'h0, {63'h0, irq});
        r.first_src = 64'h3F80_0000;
        e = '0;
        e.valid = 1'h1;
        e.exc_unimpl = 1'h1;
        r.fmt = FCM_FMT_WORD;
        step(r, 1'h0, e);
        r.fmt = FCM_FMT_LONG;
        step(r, 1'h0, e);
        step('0, 1'h0, '0);
        apb(1'h1, `FCM_OFF_CTRL, 32'h0, 32'h0, 1'h0);
        r.fmt = FCM_FMT_SINGLE;
        r.condn = 5'h10;
        e = '0;
        e.valid = 1'h1;
        e.exc_unusable = 1'h1;
        step(r, 1'h0, e);
        step('0, 1'h0, '0);
        @(posedge i_clk);
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clk);
        // Status and mask still set here, so irq would be high without reset
        chk_val("irq", 64'h0, {63'h0, irq});
        chk_res('0);
        i_rst_n <= 1'h1;
        apb(1'h0, `FCM_OFF_CTRL, 32'h0, 32'h2, 1'h0);
        apb(1'h0, `FCM_OFF_STATUS, 32'h0, 32'h0, 1'h0);
        apb(1'h0, `FCM_OFF_IRQ_MASK, 32'h0, 32'h0, 1'h0);
        give_verdict();
    end

    initial
    begin
        #1_000_000;
        miscompares++;
        give_verdict();
    end
endmodule
